// ==== instruction_format_decoder.sv ====
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module instruction_format_decoder
   import instr_dec_pkg::*;
#(
   parameter logic [7:0] OPSZ_PFX = 8'h66,
   parameter logic [7:0] ADSZ_PFX = 8'h67,
   parameter logic [7:0] ESC_BYTE = 8'h0f
) (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Instruction byte stream
   input wire logic in_valid,
   input wire logic [7:0] in_byte,
   output logic in_ready,
   // Format hints, sampled with the final opcode byte
   input wire logic hint_modrm,
   input wire logic hint_w,
   input wire logic [1:0] hint_imm,
   input wire logic [1:0] hint_reg_pos,
   // Decoded instruction, valid while dec_valid
   output logic dec_valid,
   output logic [7:0] dec_opcode,
   output logic [7:0] dec_opcode2,
   output logic dec_two_byte,
   output logic dec_op32,
   output logic dec_addr32,
   output logic [1:0] dec_opsize,
   output logic dec_dir,
   output logic dec_sext,
   output logic [3:0] dec_cond,
   output logic dec_has_modrm,
   output logic [1:0] dec_mode,
   output logic [2:0] dec_mid,
   output logic [2:0] dec_rm,
   output logic dec_has_sib,
   output logic [1:0] dec_scale,
   output logic [2:0] dec_index,
   output logic [2:0] dec_base,
   output logic [2:0] dec_gpr,
   output logic [1:0] dec_legacy_segment_select,
   output logic [2:0] dec_extended_segment_select,
   output logic [2:0] dec_disp_len,
   output logic [31:0] dec_disp,
   output logic [2:0] dec_imm_len,
   output logic [31:0] dec_imm,
   output logic [3:0] dec_wr_mask
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      dec_state_e st;
      logic op_pfx;
      logic ad_pfx;
      logic two;
      logic [7:0] opc1;
      logic [7:0] opc2;
      logic [7:0] last;
      logic has_modrm;
      logic [7:0] modrm;
      logic has_sib;
      logic [7:0] sib;
      logic has_w;
      imm_kind_e imm_kind;
      reg_pos_e reg_pos;
      logic [2:0] cnt;
      logic [2:0] disp_len;
      logic [2:0] imm_len;
      logic [31:0] disp;
      logic [31:0] imm;
      logic op32;
      logic addr32;
      opsize_e opsize;
      logic [2:0] gpr;
      logic [3:0] wr_mask;
      logic in_ready;
      logic dec_valid;
      logic [1:0] ctrl;
      logic [15:0] count;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } dec_s;

   dec_s r;
   dec_s n;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Displacement length from the addressing bytes
   function automatic logic [2:0] disp_bytes(input logic a32,
      input logic [7:0] mrm, input logic [7:0] sb, input logic use_sib);
      logic [1:0] md;
      logic [2:0] rm;
      md = mrm[MOD_LSB +: MOD_W];
      rm = mrm[RM_LSB +: FLD_W];
      disp_bytes = LEN_0;
      if (md == MOD_REG) begin
         disp_bytes = LEN_0;
      end else if (md == MOD_DISP8) begin
         disp_bytes = LEN_1;
      end else if (!a32) begin
         if (md == MOD_DISPF || rm == RM_DIRECT16) begin
            disp_bytes = LEN_2;
         end
      end else if (md == MOD_DISPF || rm == RM_DIRECT32) begin
         disp_bytes = LEN_4;
      end else if (use_sib && sb[BASE_LSB +: FLD_W] == RM_DIRECT32) begin
         disp_bytes = LEN_4;
      end
   endfunction : disp_bytes

   // Immediate length from its kind and operation size
   function automatic logic [2:0] imm_bytes(input imm_kind_e k,
      input logic o32);
      case (k)
         IMM_BYTE: imm_bytes = LEN_1;
         IMM_WORD: imm_bytes = LEN_2;
         IMM_FULL: imm_bytes = o32 ? LEN_4 : LEN_2;
         default: imm_bytes = LEN_0;
      endcase
   endfunction : imm_bytes

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   // All work is gated by ce, so a low enable freezes everything
   always_comb begin
      logic take;
      logic opc_done;
      logic addr_done;
      logic fin;
      logic eff_d;
      logic setup;
      logic acc;
      take = 1'b0;
      opc_done = 1'b0;
      addr_done = 1'b0;
      fin = 1'b0;
      eff_d = 1'b0;
      setup = 1'b0;
      acc = 1'b0;
      n = r;
      if (ce) begin
         take = in_valid & r.in_ready;
         setup = psel & ~penable;
         acc = psel & penable & r.pready;
         // Legacy modes carry no descriptor, so default is 16-bit
         eff_d = r.ctrl[CTRL_LEGACY_BIT] ? 1'b0 : r.ctrl[CTRL_D_BIT];
         n.dec_valid = 1'b0;

         // Register bus: zero-wait, data prepared during setup
         n.pready = setup;
         if (setup) begin
            n.pslverr = 1'b0;
            if (paddr == CTRL_OFS) begin
               n.prdata = {30'h0, r.ctrl};
            end else if (paddr == STAT_OFS) begin
               n.prdata = {16'h0, r.last, 5'h0,
                  (r.st != ST_PFX) | r.op_pfx | r.ad_pfx,
                  r.addr32, r.op32};
            end else if (paddr == CNT_OFS) begin
               n.prdata = {16'h0, r.count};
            end else begin
               n.prdata = 32'h0;
               n.pslverr = 1'b1;
            end
         end
         if (acc && pwrite) begin
            if (paddr == CTRL_OFS) begin
               n.ctrl = pwdata[1:0];
            end else if (paddr == CNT_OFS) begin
               n.count = 16'h0;
            end
         end

         // Byte-stream sequencer
         case (r.st)
            ST_PFX: begin
               if (take) begin
                  if (in_byte == OPSZ_PFX) begin
                     n.op_pfx = 1'b1;
                  end else if (in_byte == ADSZ_PFX) begin
                     n.ad_pfx = 1'b1;
                  end else begin
                     // Prefix toggles default, in any mode
                     n.op32 = eff_d ^ r.op_pfx;
                     n.addr32 = eff_d ^ r.ad_pfx;
                     n.opc1 = in_byte;
                     n.last = in_byte;
                     if (in_byte == ESC_BYTE) begin
                        n.two = 1'b1;
                        n.st = ST_OPC2;
                     end else begin
                        opc_done = 1'b1;
                     end
                  end
               end
            end
            ST_OPC2: begin
               if (take) begin
                  n.opc2 = in_byte;
                  n.last = in_byte;
                  opc_done = 1'b1;
               end
            end
            ST_MODRM: begin
               if (take) begin
                  n.modrm = in_byte;
                  if (r.addr32 && in_byte[RM_LSB +: FLD_W] == RM_SIB &&
                      in_byte[MOD_LSB +: MOD_W] != MOD_REG) begin
                     n.st = ST_SIB;
                  end else begin
                     n.disp_len = disp_bytes(r.addr32, in_byte, 8'h0,
                        1'b0);
                     addr_done = 1'b1;
                  end
               end
            end
            ST_SIB: begin
               if (take) begin
                  n.sib = in_byte;
                  n.has_sib = 1'b1;
                  n.disp_len = disp_bytes(r.addr32, r.modrm, in_byte,
                     1'b1);
                  addr_done = 1'b1;
               end
            end
            ST_DISP: begin
               if (take) begin
                  n.disp[r.cnt*8 +: 8] = in_byte;
                  n.cnt = r.cnt + 3'h1;
                  if (n.cnt == r.disp_len) begin
                     n.cnt = 3'h0;
                     // Immediate only after every displacement byte
                     if (r.imm_len != LEN_0) begin
                        n.st = ST_IMM;
                     end else begin
                        fin = 1'b1;
                     end
                  end
               end
            end
            ST_IMM: begin
               if (take) begin
                  n.imm[r.cnt*8 +: 8] = in_byte;
                  n.cnt = r.cnt + 3'h1;
                  if (n.cnt == r.imm_len) begin
                     fin = 1'b1;
                  end
               end
            end
            ST_EMIT: begin
               // Overrides cleared so they affect one instruction
               n.op_pfx = 1'b0;
               n.ad_pfx = 1'b0;
               n.two = 1'b0;
               n.opc2 = 8'h0;
               n.has_modrm = 1'b0;
               n.modrm = 8'h0;
               n.has_sib = 1'b0;
               n.sib = 8'h0;
               n.disp = 32'h0;
               n.imm = 32'h0;
               n.disp_len = LEN_0;
               n.imm_len = LEN_0;
               n.cnt = 3'h0;
               n.st = ST_PFX;
            end
            default: n.st = ST_PFX;
         endcase

         // Last opcode byte: latch the format hints
         if (opc_done) begin
            n.has_modrm = hint_modrm;
            n.has_w = hint_w;
            n.imm_kind = imm_kind_e'(hint_imm);
            n.reg_pos = reg_pos_e'(hint_reg_pos);
            n.imm_len = imm_bytes(imm_kind_e'(hint_imm), n.op32);
            n.disp_len = LEN_0;
            if (hint_modrm) begin
               n.st = ST_MODRM;
            end else begin
               addr_done = 1'b1;
            end
         end

         // Addressing done: displacement, then immediate
         if (addr_done) begin
            n.cnt = 3'h0;
            if (n.disp_len != LEN_0) begin
               n.st = ST_DISP;
            end else if (n.imm_len != LEN_0) begin
               n.st = ST_IMM;
            end else begin
               fin = 1'b1;
            end
         end

         // Final byte: resolve derived fields and present them
         if (fin) begin
            n.st = ST_EMIT;
            n.dec_valid = 1'b1;
            n.count = n.count + 16'h1;
            if (n.disp_len == LEN_1) begin
               n.disp = {{24{n.disp[7]}}, n.disp[7:0]};
               if (!n.addr32) begin
                  n.disp[31:16] = 16'h0;
               end
            end
            if (n.has_w && !n.last[W_BIT]) begin
               n.opsize = SZ_8;
            end else begin
               n.opsize = n.op32 ? SZ_32 : SZ_16;
            end
            // Short immediate with the S bit set sign-extended to the operation size
            if (n.imm_kind == IMM_BYTE && n.last[S_BIT] &&
                n.opsize != SZ_8) begin
               n.imm = {{24{n.imm[7]}}, n.imm[7:0]};
               if (!n.op32) begin
                  n.imm[31:16] = 16'h0;
               end
            end
            case (n.reg_pos)
               REG_OPC: n.gpr = n.last[RM_LSB +: FLD_W];
               REG_MID: n.gpr = n.modrm[REG_LSB +: FLD_W];
               REG_RM: n.gpr = n.modrm[RM_LSB +: FLD_W];
               default: n.gpr = 3'h0;
            endcase
            // Lanes written: narrow writes leave upper lanes alone
            case (n.opsize)
               SZ_32: n.wr_mask = MASK_32;
               SZ_16: n.wr_mask = MASK_16;
               default: n.wr_mask = n.gpr[BYTE_HI_BIT] ?
                  MASK_B1 : MASK_B0;
            endcase
         end
         n.in_ready = (n.st != ST_EMIT);
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
         r.st <= ST_PFX;
         r.in_ready <= 1'b1;
         r.ctrl <= CTRL_RST;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------
   // Outputs, all from the state register
   // ----------------------------------------
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign in_ready = r.in_ready;
   assign dec_valid = r.dec_valid;
   assign dec_opcode = r.opc1;
   assign dec_opcode2 = r.opc2;
   assign dec_two_byte = r.two;
   assign dec_op32 = r.op32;
   assign dec_addr32 = r.addr32;
   assign dec_opsize = r.opsize;
   assign dec_dir = r.last[D_BIT];
   assign dec_sext = r.last[S_BIT];
   assign dec_cond = r.last[COND_LSB +: COND_W];
   assign dec_has_modrm = r.has_modrm;
   assign dec_mode = r.modrm[MOD_LSB +: MOD_W];
   assign dec_mid = r.modrm[REG_LSB +: FLD_W];
   assign dec_rm = r.modrm[RM_LSB +: FLD_W];
   assign dec_has_sib = r.has_sib;
   assign dec_scale = r.sib[SS_LSB +: SS_W];
   assign dec_index = r.sib[IDX_LSB +: FLD_W];
   assign dec_base = r.sib[BASE_LSB +: FLD_W];
   assign dec_gpr = r.gpr;
   // Segment selects; meaningful only for instructions that use them
   assign dec_legacy_segment_select =
      r.last[LSEG_LSB +: LSEG_W];
   assign dec_extended_segment_select =
      r.modrm[REG_LSB +: FLD_W];
   assign dec_disp_len = r.disp_len;
   assign dec_disp = r.disp;
   assign dec_imm_len = r.imm_len;
   assign dec_imm = r.imm;
   assign dec_wr_mask = r.wr_mask;

endmodule : instruction_format_decoder

// ==== instr_dec_pkg.sv ====
package instr_dec_pkg;

   // ----------------------------------------
   // Opcode sub-field positions
   // ----------------------------------------
   localparam int W_BIT = 0;
   localparam int D_BIT = 1;
   localparam int S_BIT = 1;
   localparam int COND_LSB = 0;
   localparam int COND_W = 4;
   localparam int LSEG_LSB = 3;
   localparam int LSEG_W = 2;

   // ----------------------------------------
   // Addressing byte layouts
   // ----------------------------------------
   localparam int MOD_LSB = 6;
   localparam int MOD_W = 2;
   localparam int REG_LSB = 3;
   localparam int RM_LSB = 0;
   localparam int FLD_W = 3;
   localparam int SS_LSB = 6;
   localparam int SS_W = 2;
   localparam int IDX_LSB = 3;
   localparam int BASE_LSB = 0;
   localparam int BYTE_HI_BIT = 2;

   localparam logic [1:0] MOD_NODISP = 2'h0;
   localparam logic [1:0] MOD_DISP8 = 2'h1;
   localparam logic [1:0] MOD_DISPF = 2'h2;
   localparam logic [1:0] MOD_REG = 2'h3;
   localparam logic [2:0] RM_SIB = 3'h4;
   localparam logic [2:0] RM_DIRECT16 = 3'h6;
   localparam logic [2:0] RM_DIRECT32 = 3'h5;

   // ----------------------------------------
   // Field lengths in bytes and lane masks
   // ----------------------------------------
   localparam logic [2:0] LEN_0 = 3'h0;
   localparam logic [2:0] LEN_1 = 3'h1;
   localparam logic [2:0] LEN_2 = 3'h2;
   localparam logic [2:0] LEN_4 = 3'h4;
   localparam logic [3:0] MASK_B0 = 4'h1;
   localparam logic [3:0] MASK_B1 = 4'h2;
   localparam logic [3:0] MASK_16 = 4'h3;
   localparam logic [3:0] MASK_32 = 4'hf;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] CNT_OFS = 8'h08;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam int CTRL_D_BIT = 0;
   localparam int CTRL_LEGACY_BIT = 1;

   // ----------------------------------------
   // Enumerations
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_PFX, ST_OPC2, ST_MODRM, ST_SIB, ST_DISP, ST_IMM, ST_EMIT
   } dec_state_e;

   typedef enum logic [1:0] {
      IMM_NONE, IMM_BYTE, IMM_WORD, IMM_FULL
   } imm_kind_e;

   typedef enum logic [1:0] {
      REG_NONE, REG_OPC, REG_MID, REG_RM
   } reg_pos_e;

   typedef enum logic [1:0] {
      SZ_8, SZ_16, SZ_32
   } opsize_e;

endpackage : instr_dec_pkg

// ==== instr_fmt_sva.sv ====
`timescale 1ns/1ps
module instr_fmt_sva
   import instr_dec_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Decoder results
   input wire logic in_ready,
   input wire logic dec_valid,
   input wire logic [7:0] dec_opcode,
   input wire logic [7:0] dec_opcode2,
   input wire logic dec_two_byte,
   input wire logic dec_op32,
   input wire logic dec_addr32,
   input wire logic [1:0] dec_opsize,
   input wire logic dec_dir,
   input wire logic [3:0] dec_cond,
   input wire logic dec_has_modrm,
   input wire logic [1:0] dec_mode,
   input wire logic [2:0] dec_mid,
   input wire logic [2:0] dec_rm,
   input wire logic dec_has_sib,
   input wire logic [1:0] dec_legacy_segment_select,
   input wire logic [2:0] dec_extended_segment_select,
   input wire logic [2:0] dec_disp_len,
   input wire logic [2:0] dec_imm_len,
   input wire logic [31:0] dec_imm,
   input wire logic [3:0] dec_wr_mask
);
   // ----------------------------------------
   // Opcode sub-fields come from the final opcode byte
   // ----------------------------------------
   logic [7:0] last_opc;
   assign last_opc = dec_two_byte ? dec_opcode2 : dec_opcode;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Emit cycle holds input off, next cycle input reopens
   sequence s_emit;
      dec_valid && !in_ready;
   endsequence
   sequence s_resume;
      !dec_valid && in_ready;
   endsequence

   a_emit_resume: assert property (dec_valid |-> s_emit ##1 s_resume)
      else $error("emit cycle length or input hold wrong");
   a_sib_present: assert property (dec_valid && dec_addr32 &&
      dec_has_modrm && dec_rm == RM_SIB && dec_mode != MOD_REG |-> dec_has_sib)
      else $error("sib byte missing");
   a_sib_cause: assert property (dec_valid && dec_has_sib |->
      dec_addr32 && dec_rm == RM_SIB && dec_mode != MOD_REG)
      else $error("sib byte without its cause");
   a_disp_byte: assert property (dec_valid && dec_has_modrm &&
      dec_mode == MOD_DISP8 |-> dec_disp_len == LEN_1)
      else $error("disp8 length wrong");
   a_reg_nodisp: assert property (dec_valid && dec_has_modrm &&
      dec_mode == MOD_REG |-> dec_disp_len == LEN_0 && !dec_has_sib)
      else $error("register mode took address bytes");
   a_size_code: assert property (dec_valid && dec_opsize != SZ_8 |->
      dec_opsize == (dec_op32 ? SZ_32 : SZ_16))
      else $error("operand size disagrees with op32");
   a_narrow_lane: assert property (dec_valid && dec_opsize == SZ_8 |->
      $onehot(dec_wr_mask) && dec_wr_mask[3:2] == 2'h0)
      else $error("byte write lanes wrong");
   a_word_lane: assert property (dec_valid && dec_opsize == SZ_16 |->
      dec_wr_mask == MASK_16)
      else $error("word write lanes wrong");
   a_dir_bit: assert property (dec_valid |-> dec_dir == last_opc[D_BIT])
      else $error("direction bit wrong");
   a_cond_bits: assert property (dec_valid |-> dec_cond == last_opc[3:0])
      else $error("condition field wrong");
   a_seg_fields: assert property (dec_valid |->
      dec_legacy_segment_select == last_opc[4:3] &&
      dec_extended_segment_select == dec_mid)
      else $error("segment select wrong");
   a_imm_narrow: assert property (dec_valid && !dec_op32 |->
      dec_imm[31:16] == 16'h0000 && dec_imm_len != LEN_4)
      else $error("16-bit immediate too wide");
endmodule : instr_fmt_sva

bind instruction_format_decoder instr_fmt_sva u_instr_fmt_sva (.*);

// ==== prefetch_model.sv ====
`timescale 1ns/1ps
module prefetch_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Byte stream toward the decoder
   input wire logic ce,
   input wire logic in_ready,
   output logic in_valid,
   output logic [7:0] in_byte
);
   // Queue filled by the bench; slow puts an idle cycle between bytes
   logic [7:0] q[$];
   logic slow = 1'b0;
   logic gap;

   // Offer advances only when the current byte was taken
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         in_valid <= 1'b0;
         in_byte <= 8'h00;
         gap <= 1'b0;
      end else if (!in_valid || (in_ready && ce)) begin
         if (q.size() > 0 && !(slow && !gap)) begin
            in_valid <= 1'b1;
            in_byte <= q.pop_front();
            gap <= 1'b0;
         end else begin
            // Idle byte wanders so stale data never looks valid
            in_valid <= 1'b0;
            in_byte <= ~in_byte;
            gap <= 1'b1;
         end
      end
   end
endmodule : prefetch_model

// ==== test_instruction_format_decoder.sv ====
`timescale 1ns/1ps
module test_instruction_format_decoder
   import instr_dec_pkg::*;
;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic clk, reset_n, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, in_byte, dec_opcode, dec_opcode2;
   logic [31:0] pwdata, prdata, dec_disp, dec_imm, rd;
   logic in_valid, in_ready, hint_modrm, hint_w, dec_valid, err;
   logic [1:0] hint_imm, hint_reg_pos, dec_opsize, dec_mode, dec_scale;
   logic dec_two_byte, dec_op32, dec_addr32, dec_dir, dec_sext;
   logic dec_has_modrm, dec_has_sib;
   logic [3:0] dec_cond, dec_wr_mask;
   logic [2:0] dec_mid, dec_rm, dec_index, dec_base, dec_gpr;
   logic [1:0] dec_legacy_segment_select;
   logic [2:0] dec_extended_segment_select, dec_disp_len, dec_imm_len;
   int failures = 0;
   int checks = 0;

   instruction_format_decoder u_instruction_format_decoder (.*);
   prefetch_model u_prefetch_model (.*);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [39:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic stop_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   // One APB transfer; wait for pready is bounded
   task automatic apb(input logic [7:0] a, input logic w,
         input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         failures++;
         stop_test();
      end
   endtask : apb

   // Queue one instruction and stop in its emit cycle
   task automatic run(input logic [7:0] b[$], input logic m, w,
         input logic [1:0] imm, pos);
      int n;
      @(posedge clk);
      hint_modrm <= m;
      hint_w <= w;
      hint_imm <= imm;
      hint_reg_pos <= pos;
      #1;
      foreach (b[i]) u_prefetch_model.q.push_back(b[i]);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (dec_valid !== 1'b1 && n < 40);
      if (dec_valid !== 1'b1) begin
         failures++;
         stop_test();
      end
   endtask : run

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {reset_n, psel, penable, pwrite, hint_modrm, hint_w} = 6'h00;
      {hint_imm, hint_reg_pos, paddr, pwdata} = 44'h0;
      ce = 1'b1;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      apb(CTRL_OFS, 1'b0, 32'h0);
      chk("ctrl_reset", rd, 32'h0);
      apb(8'h0c, 1'b0, 32'h0);
      chk("unmapped", {err, rd}, {1'b1, 32'h0});
      // Prefix with a slow stream, then the same opcode bare
      u_prefetch_model.slow <= 1'b1;
      run('{8'h66, 8'h05, 8'h78, 8'h56, 8'h34, 8'h12}, 0, 1, 3, 0);
      chk("size_pfx", {dec_op32, dec_addr32, dec_opsize}, {2'h2, SZ_32});
      chk("imm32", {dec_imm_len, dec_imm}, {LEN_4, 32'h12345678});
      u_prefetch_model.slow <= 1'b0;
      run('{8'h05, 8'h34, 8'h12}, 0, 1, 3, 0);
      chk("size_bare", {dec_op32, dec_addr32, dec_opsize}, {2'h0, SZ_16});
      chk("imm16", {dec_imm_len, dec_imm}, {LEN_2, 32'h1234});
      // Address prefix, SIB and negative disp8
      run('{8'h67, 8'h8b, 8'h44, 8'hcb, 8'hf8}, 1, 1, 0, 2);
      chk("sib", {dec_has_sib, dec_scale, dec_index, dec_base}, 9'h1cb);
      chk("modrm", {dec_mode, dec_mid, dec_rm, dec_dir}, 9'h089);
      chk("disp8", {dec_disp_len, dec_disp}, {LEN_1, 32'hfffffff8});
      chk("addr", {dec_op32, dec_addr32, dec_gpr}, 5'h08);
      run('{8'h8b, 8'h06, 8'h34, 8'h12}, 1, 1, 0, 2);
      chk("disp16", {dec_has_sib, dec_disp_len, dec_disp}, {1'b0, LEN_2, 32'h1234});
      run('{8'h8b, 8'h44, 8'hf8}, 1, 1, 0, 2);
      chk("nosib16", {dec_has_sib, dec_disp_len, dec_disp}, {1'b0, LEN_1, 32'hfff8});
      // Default size 32, then both prefixes invert it
      apb(CTRL_OFS, 1'b1, 32'h1);
      run('{8'h83, 8'hc0, 8'hf0}, 1, 1, 1, 3);
      chk("size_d1", {dec_op32, dec_addr32, dec_opsize}, {2'h3, SZ_32});
      chk("sext32", {dec_sext, dec_imm_len, dec_imm}, {1'b1, LEN_1, 32'hfffffff0});
      chk("lanes32", {dec_wr_mask, dec_gpr}, {MASK_32, 3'h0});
      run('{8'h66, 8'h67, 8'h83, 8'hc0, 8'hf0}, 1, 1, 1, 3);
      chk("size_inv", {dec_op32, dec_addr32, dec_opsize}, {2'h0, SZ_16});
      chk("sext16", {dec_sext, dec_imm_len, dec_imm}, {1'b1, LEN_1, 32'hfff0});
      chk("lanes16", dec_wr_mask, MASK_16);
      // Legacy mode forces 16, prefixes still reach 32
      apb(CTRL_OFS, 1'b1, 32'h3);
      apb(CTRL_OFS, 1'b0, 32'h0);
      chk("ctrl_rw", rd, 32'h3);
      run('{8'h05, 8'h34, 8'h12}, 0, 1, 3, 0);
      chk("size_legacy", {dec_op32, dec_addr32, dec_opsize}, {2'h0, SZ_16});
      run('{8'h66, 8'h67, 8'h05, 8'h78, 8'h56, 8'h34, 8'h12}, 0, 1, 3, 0);
      chk("size_lpfx", {dec_op32, dec_addr32, dec_opsize}, {2'h3, SZ_32});
      // Byte operand in a high-byte register, taken from the opcode
      run('{8'hb4, 8'h7f}, 0, 1, 1, 1);
      chk("narrow", {dec_opsize, dec_gpr, dec_wr_mask}, {SZ_8, 3'h4, MASK_B1});
      // Escape opcode with condition field
      run('{8'h0f, 8'h85, 8'h34, 8'h12}, 0, 0, 3, 0);
      chk("twobyte", {dec_opcode, dec_two_byte, dec_opcode2, dec_cond},
         {8'h0f, 13'h1855});
      chk("imm_last", {dec_imm_len, dec_imm}, {LEN_2, 32'h1234});
      // Segment selects in register mode
      run('{8'h8e, 8'hd8}, 1, 0, 0, 0);
      chk("seg", {dec_legacy_segment_select, dec_extended_segment_select,
         dec_mode, dec_disp_len, dec_has_modrm},
         {2'h1, 3'h3, MOD_REG, LEN_0, 1'b1});
      // Enable low for three cycles mid-stream must lose no byte
      fork
         run('{8'h05, 8'h34, 8'h12}, 0, 1, 3, 0);
         begin
            repeat (2) @(posedge clk);
            ce <= 1'b0;
            repeat (3) @(posedge clk);
            ce <= 1'b1;
         end
      join
      chk("ce_hold", {dec_imm_len, dec_imm}, {LEN_2, 32'h1234});
      apb(STAT_OFS, 1'b0, 32'h0);
      chk("status", rd, 32'h0500);
      // Instruction count, then clear by any write
      apb(CNT_OFS, 1'b0, 32'h0);
      chk("count", rd, 32'hd);
      apb(CNT_OFS, 1'b1, 32'h5);
      apb(CNT_OFS, 1'b0, 32'h0);
      chk("count_clr", rd, 32'h0);
      stop_test();
   end
endmodule : test_instruction_format_decoder
